// ---- hw/tvu_regs.vh ----
// Constants of the trap and vector unit: trap numbers, flag positions, reset values.
// Assumes a 24-bit code address made of an 8-bit vector segment and a 16-bit offset.
// Notes on behaviour
// [RL1] Every vector address lies in the segment held by the vector segment register.
// [RL2] Vector spacing comes from the spacing field of configuration register one.
// [RL3] After reset spacing is four bytes: address is base plus four times trap number.
// [RL4] A hardware trap branches at once, unmaskably, to its own vector entry.
// [RL5] Each hardware trap sets its own bit in the trap flag register.
// [RL6] A hardware trap preempts code unless a higher priority trap is in service; nothing but a reset is granted while svcReq is high, so it waits for svcDone.
// [RL7] During a trap service, standard and event controller requests are held off.
// [RL8] Class A traps use trap numbers 02, 04, 06, 08 at offsets 0008 to 0020.
// [RL9] Class B traps share trap number 0A at offset 0028, told apart by flags.
// [RL10] Software trap takes numbers 00 to 7F and keeps current CPU priority.
// [RL11] Serial bus transfer node uses trap number 40, offset 0100.
// [RL12] Event controller subchannel end node uses trap number 4C, offset 0130.
// [RL13] Each node has request, enable and a sixteen level priority field.
// [RL14] An accepted interrupt is interrupted only by a higher priority request.
// [RL15] Software may set a request bit of a node with no peripheral attached.
// [RL16] All resets vector to offset 0000 with trap number 00.
// [RL17] Class A traps are served before class B traps when both pend.
`ifndef TVU_REGS_VH
`define TVU_REGS_VH
`define TVU_TN_RESET 7'h00
`define TVU_TN_NMI 7'h02
`define TVU_TN_STKOV 7'h04
`define TVU_TN_STKUN 7'h06
`define TVU_TN_SBRK 7'h08
`define TVU_TN_CLASSB 7'h0A
`define TVU_TN_SERIAL 7'h40
`define TVU_TN_SUBEND 7'h4C
`define TVU_NODES 4
`define TVU_NODE_SERIAL 2'h0
`define TVU_NODE_SUBEND 2'h1
`define TVU_SPACING_RST 2'h1
`define TVU_SEG_RST 8'h00
`define TVU_F_NMI 15
`define TVU_F_STKOV 14
`define TVU_F_STKUN 13
`define TVU_F_SBRK 3
`define TVU_F_UNDOP 7
`define TVU_F_PMACC 6
`define TVU_F_PROT 2
`define TVU_F_ILLOP 0
`define TVU_PRIO_A 2'h3
`define TVU_PRIO_B 2'h2
`define TVU_PRIO_NONE 2'h0
`define TVU_NODE_BASE0 7'h40
`define TVU_NODE_BASE1 7'h4C
`define TVU_NODE_BASE2 7'h41
`define TVU_NODE_BASE3 7'h3F
`endif

// ---- hw/tvu_vector_calc.v ----
// Vector address former: segment, spacing and trap number into a 24-bit address.
// Assumes spacing codes 0..3 mean 2, 4, 8 and 16 bytes; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module tvu_vector_calc (
    // Inputs
    input wire [7:0] segment,
    input wire [1:0] spacing,
    input wire [6:0] trapNum,
    // Result
    output wire [23:0] vecAddr
);
    wire [15:0] offs;
    // The offset wraps inside the segment rather than spilling into the next one.
    // The shift count is one bit wider than the code, so code 3 gives a shift of four.
    assign offs = {9'h000, trapNum} << ({1'b0, spacing} + 3'h1); // [RL2]
    assign vecAddr = {segment, offs}; // [RL1]
endmodule // tvu_vector_calc
`default_nettype wire

// ---- hw/tvu_trap_unit.v ----
// Trap and vector unit: hardware trap flags, node arbitration and vector forming.
// Assumes trap inputs and node set pulses are single-cycle pulses on mclk, and the
// sequencer returns svcDone once a granted service has finished.
`timescale 1ns/1ps
`include "tvu_regs.vh"
`default_nettype none
module tvu_trap_unit (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Configuration
    input wire [7:0] vecSegWr,
    input wire vecSegWe,
    input wire [1:0] spacingWr,
    input wire spacingWe,
    output reg [7:0] vector_segment_reg,
    output reg [1:0] vector_spacing_field,
    // Hardware trap events
    input wire nmiEv,
    input wire stackOverEv,
    input wire stackUnderEv,
    input wire softBreakEv,
    input wire undefOpEv,
    input wire progAccessEv,
    input wire protInstrEv,
    input wire illegalOpEv,
    input wire resetEv,
    // Trap flag register access
    input wire [15:0] flagClr,
    output reg [15:0] trap_flag_register,
    // Node control, one field per node
    input wire [3:0] nodeReqIn,
    input wire [3:0] nodeSwSet,
    input wire [3:0] nodeEnWr,
    input wire [15:0] nodePrioWr,
    input wire nodeCfgWe,
    output reg [3:0] node_request_bit,
    // Software trap
    input wire swTrapReq,
    input wire [6:0] swTrapNum,
    // Sequencer handshake
    input wire [3:0] cpuPrio,
    input wire svcDone,
    output reg svcReq,
    output reg [6:0] svcTrapNum,
    output reg [23:0] svcVector,
    output reg [3:0] svcPrio,
    output reg svcIsTrap,
    output reg [1:0] trapLevel
);
    reg [3:0] nodeEn;
    reg [15:0] nodePrio;
    reg [15:0] flagSet;
    reg [3:0] nodeNext;
    reg winValid;
    reg [1:0] winIdx;
    reg [3:0] winPrio;
    reg [6:0] pickNum;
    reg [3:0] pickPrio;
    reg pickIsTrap;
    reg [1:0] pickLevel;
    reg pickValid;
    reg [1:0] pickNode;
    reg pickNodeHit;
    wire [23:0] pickVec;
    wire aPend;
    wire bPend;
    integer i;

    function [6:0] nodeTrap;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: nodeTrap = `TVU_NODE_BASE0; // [RL11]
                2'h1: nodeTrap = `TVU_NODE_BASE1; // [RL12]
                2'h2: nodeTrap = `TVU_NODE_BASE2;
                default: nodeTrap = `TVU_NODE_BASE3;
            endcase
        end
    endfunction

    assign aPend = trap_flag_register[`TVU_F_NMI] | trap_flag_register[`TVU_F_STKOV] |
                   trap_flag_register[`TVU_F_STKUN] | trap_flag_register[`TVU_F_SBRK];
    assign bPend = trap_flag_register[`TVU_F_UNDOP] | trap_flag_register[`TVU_F_PMACC] |
                   trap_flag_register[`TVU_F_PROT] | trap_flag_register[`TVU_F_ILLOP];

    always @* begin
        flagSet = 16'h0000;
        flagSet[`TVU_F_NMI] = nmiEv; // [RL5]
        flagSet[`TVU_F_STKOV] = stackOverEv;
        flagSet[`TVU_F_STKUN] = stackUnderEv;
        flagSet[`TVU_F_SBRK] = softBreakEv;
        flagSet[`TVU_F_UNDOP] = undefOpEv;
        flagSet[`TVU_F_PMACC] = progAccessEv;
        flagSet[`TVU_F_PROT] = protInstrEv;
        flagSet[`TVU_F_ILLOP] = illegalOpEv;
    end

    // Highest priority enabled node; lower index wins a tie.
    always @* begin
        winValid = 1'b0;
        winIdx = 2'h0;
        winPrio = 4'h0;
        for (i = `TVU_NODES - 1; i >= 0; i = i - 1) begin
            if (node_request_bit[i] && nodeEn[i] &&
                (!winValid || nodePrio[i*4 +: 4] >= winPrio)) begin // [RL13]
                winValid = 1'b1;
                winIdx = i[1:0];
                winPrio = nodePrio[i*4 +: 4];
            end
        end
    end

    // Selection: class A before class B before interrupts and software traps.
    always @* begin
        pickValid = 1'b0;
        pickNum = `TVU_TN_RESET;
        pickPrio = cpuPrio;
        pickIsTrap = 1'b0;
        pickLevel = `TVU_PRIO_NONE;
        pickNode = 2'h0;
        pickNodeHit = 1'b0;
        if (aPend && trapLevel < `TVU_PRIO_A) begin // [RL6] [RL17]
            pickValid = 1'b1;
            pickIsTrap = 1'b1;
            pickLevel = `TVU_PRIO_A;
            pickPrio = 4'hF;
            if (trap_flag_register[`TVU_F_NMI]) begin
                pickNum = `TVU_TN_NMI; // [RL8]
            end else if (trap_flag_register[`TVU_F_STKOV]) begin
                pickNum = `TVU_TN_STKOV;
            end else if (trap_flag_register[`TVU_F_STKUN]) begin
                pickNum = `TVU_TN_STKUN;
            end else begin
                pickNum = `TVU_TN_SBRK;
            end
        end else if (bPend && trapLevel < `TVU_PRIO_B) begin // [RL4] [RL6]
            pickValid = 1'b1;
            pickIsTrap = 1'b1;
            pickLevel = `TVU_PRIO_B;
            pickPrio = 4'hF;
            pickNum = `TVU_TN_CLASSB; // [RL9]
        end else if (trapLevel == `TVU_PRIO_NONE) begin // [RL7]
            if (winValid && winPrio > cpuPrio) begin // [RL14]
                pickValid = 1'b1;
                pickNum = nodeTrap(winIdx);
                pickPrio = winPrio;
                pickNode = winIdx;
                pickNodeHit = 1'b1;
            end else if (swTrapReq) begin
                pickValid = 1'b1;
                pickNum = swTrapNum; // [RL10]
                pickPrio = cpuPrio;
            end
        end
    end

    tvu_vector_calc vecCalc (
        .segment(vector_segment_reg),
        .spacing(vector_spacing_field),
        .trapNum(pickNum),
        .vecAddr(pickVec)
    );

    always @* begin
        nodeNext = (node_request_bit | nodeReqIn | nodeSwSet); // [RL15]
        if (!svcReq && pickValid && pickNodeHit) begin
            nodeNext[pickNode] = nodeReqIn[pickNode] | nodeSwSet[pickNode];
        end
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            vector_segment_reg <= `TVU_SEG_RST;
            vector_spacing_field <= `TVU_SPACING_RST; // [RL3]
            trap_flag_register <= 16'h0000;
            nodeEn <= 4'h0;
            nodePrio <= 16'h0000;
            node_request_bit <= 4'h0;
            svcReq <= 1'b1;
            svcTrapNum <= `TVU_TN_RESET; // [RL16]
            svcVector <= {`TVU_SEG_RST, 16'h0000};
            svcPrio <= 4'hF;
            svcIsTrap <= 1'b1;
            trapLevel <= `TVU_PRIO_NONE;
        end else begin
            if (vecSegWe) begin
                vector_segment_reg <= vecSegWr; // [RL1]
            end
            if (spacingWe) begin
                vector_spacing_field <= spacingWr; // [RL2]
            end
            if (nodeCfgWe) begin
                nodeEn <= nodeEnWr;
                nodePrio <= nodePrioWr; // [RL13]
            end
            // A new event wins over a clear in the same cycle.
            trap_flag_register <= (trap_flag_register & ~flagClr) | flagSet; // [RL5]
            node_request_bit <= nodeNext;
            if (resetEv) begin
                svcReq <= 1'b1;
                svcTrapNum <= `TVU_TN_RESET; // [RL16]
                svcVector <= {vector_segment_reg, 16'h0000};
                svcPrio <= 4'hF;
                svcIsTrap <= 1'b1;
                trapLevel <= `TVU_PRIO_NONE;
            end else if (svcReq) begin
                if (svcDone) begin
                    svcReq <= 1'b0;
                    trapLevel <= `TVU_PRIO_NONE;
                end
            end else if (pickValid) begin
                // The flag is left set: software reads and clears it in the handler.
                svcReq <= 1'b1; // [RL4]
                svcTrapNum <= pickNum;
                svcVector <= pickVec;
                svcPrio <= pickPrio;
                svcIsTrap <= pickIsTrap;
                trapLevel <= pickLevel;
            end
        end
    end
endmodule // tvu_trap_unit
`default_nettype wire

// ---- sim/tvu_trap_unit_assertions.sv ----
// Checker of the trap unit service outputs, bound to the unit top.
// Assumes one clock domain and the synchronous active low reset.
`timescale 1ns/1ps
`default_nettype none
module tvu_trap_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Watched ports
    input wire logic [7:0] vector_segment_reg,
    input wire logic [1:0] vector_spacing_field,
    input wire logic resetEv,
    input wire logic [15:0] trap_flag_register,
    input wire logic [3:0] cpuPrio,
    input wire logic svcDone,
    input wire logic svcReq,
    input wire logic [6:0] svcTrapNum,
    input wire logic [23:0] svcVector,
    input wire logic [3:0] svcPrio,
    input wire logic svcIsTrap,
    input wire logic [1:0] trapLevel
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_vector;
        $rose(svcReq) |-> svcVector == {vector_segment_reg,
            16'(svcTrapNum) << ({1'b0, vector_spacing_field} + 3'h1)};
    endproperty
    a_vector: assert property (p_vector) else $error("vector address wrong");
    property p_reset;
        $rose(rstn) |-> vector_spacing_field == 2'h1 && trap_flag_register == 16'h0000
            && svcReq && svcTrapNum == 7'h00 && svcVector == 24'h000000;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_nmi;
        $rose(trap_flag_register[15]) && !svcReq |=> svcReq && svcTrapNum == 7'h02
            && trapLevel == 2'h3;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not granted");
    property p_classb;
        $rose(svcReq) && svcTrapNum == 7'h0A |-> trapLevel == 2'h2 && svcIsTrap
            && |{trap_flag_register[7:6], trap_flag_register[2], trap_flag_register[0]};
    endproperty
    a_classb: assert property (p_classb) else $error("class b grant wrong");
    property p_stand;
        svcReq && !svcDone && !resetEv |=> svcReq && $stable(svcVector) && $stable(svcTrapNum);
    endproperty
    a_stand: assert property (p_stand) else $error("service changed");
    property p_blocks;
        svcReq && !svcIsTrap |-> trapLevel == 2'h0;
    endproperty
    a_blocks: assert property (p_blocks) else $error("interrupt inside trap");
    property p_node;
        $rose(svcReq) && (svcTrapNum == 7'h40 || svcTrapNum == 7'h4C)
            |-> svcPrio > $past(cpuPrio) && !svcIsTrap;
    endproperty
    a_node: assert property (p_node) else $error("node priority wrong");
    property p_order;
        $rose(svcReq) && trapLevel == 2'h2 |-> $past(trap_flag_register[15:13]) == 3'h0
            && !$past(trap_flag_register[3]);
    endproperty
    a_order: assert property (p_order) else $error("class b before a");
endmodule // tvu_trap_checker
`default_nettype wire

// ---- sim/tvu_seq_model.sv ----
// Sequencer model: ends each granted service after a programmable hold.
// Assumes svcReq stays high until the edge that samples svcDone.
`timescale 1ns/1ps
`default_nettype none
module tvu_seq_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Service handshake
    input wire logic svcReq,
    input wire logic [3:0] holdCycles,
    output logic svcDone
);
    logic [3:0] waitCount;
    // A long hold lets new trap events pile up behind the running service.
    always @(posedge mclk) begin
        if (!rstn) begin
            waitCount <= 4'h0;
            svcDone <= 1'b0;
        end else if (svcReq && !svcDone && waitCount >= holdCycles) begin
            waitCount <= 4'h0;
            svcDone <= 1'b1;
        end else begin
            waitCount <= (svcReq && !svcDone) ? waitCount + 4'h1 : 4'h0;
            svcDone <= 1'b0;
        end
    end
endmodule // tvu_seq_model
`default_nettype wire

// ---- sim/tvu_trap_unit_test.sv ----
// Self-checking bench of the trap unit with a sequencer model.
// Assumes the design folder is on the include path.
`timescale 1ns/1ps
`default_nettype none
module tvu_trap_unit_test;
    logic mclk, rstn, vecSegWe, spacingWe, nodeCfgWe, swTrapReq;
    logic [7:0] vecSegWr;
    logic [1:0] spacingWr;
    logic [8:0] ev;
    logic [15:0] flagClr, nodePrioWr;
    logic [3:0] nodeReqIn, nodeSwSet, nodeEnWr, cpuPrio, holdCycles;
    logic [6:0] swTrapNum, t;
    wire [7:0] vector_segment_reg;
    wire [1:0] vector_spacing_field, trapLevel;
    wire [15:0] trap_flag_register;
    wire [3:0] svcPrio;
    wire svcReq, svcIsTrap, svcDone;
    wire [6:0] svcTrapNum;
    wire [23:0] svcVector;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    int fp[8] = '{15, 14, 13, 3, 7, 6, 2, 0};
    tvu_trap_unit dut_u (.mclk, .rstn, .vecSegWr, .vecSegWe, .spacingWr, .spacingWe,
        .vector_segment_reg, .vector_spacing_field, .nmiEv(ev[0]), .stackOverEv(ev[1]),
        .stackUnderEv(ev[2]), .softBreakEv(ev[3]), .undefOpEv(ev[4]), .progAccessEv(ev[5]),
        .protInstrEv(ev[6]), .illegalOpEv(ev[7]), .resetEv(ev[8]), .flagClr,
        .trap_flag_register, .nodeReqIn, .nodeSwSet, .nodeEnWr, .nodePrioWr, .nodeCfgWe,
        .node_request_bit(), .swTrapReq, .swTrapNum, .cpuPrio, .svcDone, .svcReq,
        .svcTrapNum, .svcVector, .svcPrio, .svcIsTrap, .trapLevel);
    tvu_seq_model seq_u (.mclk, .rstn, .svcReq, .holdCycles, .svcDone);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [23:0] vec(input logic [7:0] vs, input logic [1:0] vp,
        input logic [6:0] vt);
        return {vs, 16'(vt) << (vp + 1)};
    endfunction
    task automatic fire(input int i);
        ev[i] = 1'b1;
        tick;
        ev[i] = 1'b0;
    endtask
    // Waits for the grant, checks it, clears flags as a handler would, waits for release.
    task automatic serve(input logic [6:0] tn, input logic [23:0] v, input logic [15:0] f, c);
        for (n = 0; svcReq !== 1'b1 && n < 40; n++) tick;
        chk("request", 24'h1, {23'h0, svcReq});
        chk("trap number", {17'h0, tn}, {17'h0, svcTrapNum});
        chk("vector", v, svcVector);
        chk("flags", {8'h0, f}, {8'h0, trap_flag_register & f});
        flagClr = c;
        tick;
        flagClr = 16'h0000;
        for (n = 0; svcReq !== 1'b0 && n < 40; n++) tick;
        chk("release", 24'h0, {23'h0, svcReq});
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {rstn, vecSegWe, spacingWe, nodeCfgWe, swTrapReq, ev, flagClr} = '0;
        {vecSegWr, spacingWr, nodeReqIn, nodeSwSet, nodeEnWr, nodePrioWr} = '0;
        {swTrapNum, cpuPrio, holdCycles} = '0;
        repeat (3) tick;
        rstn = 1'b1;
        chk("spacing", 24'h1, {22'h0, vector_spacing_field});
        serve(7'h00, 24'h000000, 16'h0000, 16'h0000);
        $display("test reset done");
        holdCycles = 4'h5;
        for (int i = 0; i < 8; i++) begin
            t = i < 4 ? 7'(2 * i + 2) : 7'h0A;
            fire(i);
            serve(t, vec(8'h00, 2'h1, t), 16'(1) << fp[i], 16'hFFFF);
        end
        $display("test traps done");
        {holdCycles, cpuPrio, nodeEnWr, nodePrioWr, nodeCfgWe} = {12'h03F, 16'h2255, 1'b1};
        tick;
        {nodeCfgWe, nodeSwSet} = 5'h01;
        tick;
        nodeSwSet = 4'h0;
        serve(7'h40, 24'h000100, 16'h0, 16'h0);
        nodeReqIn = 4'h2;
        tick;
        nodeReqIn = 4'h0;
        serve(7'h4C, 24'h000130, 16'h0, 16'h0);
        nodeSwSet = 4'h4;
        tick;
        nodeSwSet = 4'h0;
        repeat (6) tick;
        chk("held request", 24'h0, {23'h0, svcReq});
        cpuPrio = 4'h1;
        serve(7'h41, 24'h000104, 16'h0, 16'h0);
        $display("test nodes done");
        {swTrapNum, swTrapReq} = {7'h7F, 1'b1};
        tick;
        swTrapReq = 1'b0;
        chk("software priority", 24'h1, {20'h0, svcPrio});
        serve(7'h7F, 24'h0001FC, 16'h0, 16'h0);
        for (int s = 0; s < 4; s++) begin
            {vecSegWr, spacingWr, vecSegWe, spacingWe} = {8'h5A, 2'(s), 2'b11};
            tick;
            {vecSegWe, spacingWe} = 2'b00;
            chk("segment", 24'h5A, {16'h0, vector_segment_reg});
            fire(0);
            serve(7'h02, vec(8'h5A, 2'(s), 7'h02), 16'h8000, 16'hFFFF);
        end
        fire(8);
        serve(7'h00, 24'h5A0000, 16'h0, 16'h0);
        $display("test spacing done");
        ev = 9'h014;
        tick;
        ev = 9'h000;
        serve(7'h06, vec(8'h5A, 2'h3, 7'h06), 16'h2080, 16'h2000);
        serve(7'h0A, vec(8'h5A, 2'h3, 7'h0A), 16'h0080, 16'hFFFF);
        $display("test order done");
        complete_run;
    end
    initial begin
        #100000;
        fail_count++;
        complete_run;
    end
endmodule // tvu_trap_unit_test
bind tvu_trap_unit tvu_trap_checker chk_u (.mclk, .rstn, .vector_segment_reg,
    .vector_spacing_field, .resetEv, .trap_flag_register, .cpuPrio, .svcDone, .svcReq,
    .svcTrapNum, .svcVector, .svcPrio, .svcIsTrap, .trapLevel);
`default_nettype wire
